// *** core/spv_cfg.svh ***
// constants of the serial program/verify port: sizes, map, codes
// assumes inclusion by bare name from every design file
`ifndef SPV_CFG_SVH
`define SPV_CFG_SVH
`define SPV_CMD_BITS    6
`define SPV_SEG_BITS    16
`define SPV_DATA_BITS   14
`define SPV_CORE_BITS   12
`define SPV_ADDR_BITS   11
`define SPV_USER_DEPTH  1024
`define SPV_CFG_DEPTH   64
`define SPV_PC_ENTRY    11'h7ff
`define SPV_USER_TOP    11'h3ff
`define SPV_CFG_BASE    11'h400
`define SPV_ID_LAST     11'h403
`define SPV_TRIM_ADDR   11'h404
`define SPV_CFG_LAST    11'h43f
`define SPV_CP_LO       11'h040
`define SPV_CP_HI       11'h3fe
`define SPV_CP_POS      4
`define SPV_ERASED      12'hfff
`endif

// *** core/spv_pkg.sv ***
// types used by the program/verify port module spv_port
// assumes spv_cfg.svh is on the include path
`include "spv_cfg.svh"
package spv_pkg;
  typedef enum logic [0:0] {
    PH_CMD  = 1'b0,
    PH_DATA = 1'b1
  } spv_phase_e;

  typedef enum logic [3:0] {
    CMD_LOAD  = 4'h2,
    CMD_READ  = 4'h4,
    CMD_INC   = 4'h6,
    CMD_BEGIN = 4'h8,
    CMD_ERASE = 4'h9,
    CMD_END   = 4'he
  } spv_cmd_e;

  typedef enum logic [1:0] {
    RG_NONE = 2'b00,
    RG_USER = 2'b01,
    RG_CFG  = 2'b10,
    RG_CFGW = 2'b11
  } spv_region_e;

  // link side state, falling edge of the link clock
  typedef struct packed {
    spv_phase_e                ph;
    logic [4:0]                cnt;
    logic [5:0]                sh;
    logic                      rd;
    logic [`SPV_DATA_BITS-1:0] dsh;
    logic [`SPV_DATA_BITS-1:0] word;
    logic [`SPV_DATA_BITS-1:0] tx;
    logic [3:0]                code;
    logic                      req;
  } spv_link_s;

  // data pin drive, rising edge of the link clock
  typedef struct packed {
    logic oe;
    logic dat;
  } spv_drive_s;

  // system clock side state
  typedef struct packed {
    logic                      mode;
    logic                      lrst;
    logic [`SPV_ADDR_BITS-1:0] pc;
    logic                      fresh;
    logic                      seen;
    logic                      prog;
    logic [`SPV_CORE_BITS-1:0] latch;
    logic [`SPV_CORE_BITS-1:0] cfgw;
    logic [`SPV_CORE_BITS-1:0] shadow;
  } spv_core_s;
endpackage : spv_pkg

// *** core/spv_sync.sv ***
// two flip-flop level synchroniser into clk
// assumes d is a level from another domain or a pin
`timescale 1ns/1ns
`include "spv_cfg.svh"
module spv_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,  // destination clock
  input  wire logic         rst,  // synchronous reset, high
  input  wire logic [W-1:0] d,    // asynchronous level
  output logic      [W-1:0] q     // synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spv_sync_s;

  spv_sync_s s;
  spv_sync_s next_s;

  // first stage feeds the second stage only
  always_comb begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) s <= '0;
    else     s <= next_s;
  end

  assign q = s.s2;
endmodule : spv_sync

// *** core/spv_mem.sv ***
// flip-flop word array with bulk set-to-ones and one write port
// assumes write and clear never coincide; read is a plain index
`timescale 1ns/1ns
`include "spv_cfg.svh"
module spv_mem #(
  parameter int WIDTH = `SPV_CORE_BITS,
  parameter int DEPTH = `SPV_USER_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,      // system clock
  input  wire logic             rst,      // blank array, high
  input  wire logic             wr_en,    // write one word
  input  wire logic [AW-1:0]    wr_addr,  // write index
  input  wire logic [WIDTH-1:0] wr_data,  // write value
  input  wire logic             clr,      // erase all to ones
  input  wire logic [AW-1:0]    rd_addr,  // read index
  output logic      [WIDTH-1:0] rd_data   // word at rd_addr
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] w;
  } spv_mem_s;

  spv_mem_s s;
  spv_mem_s next_s;

  // erased cells read as ones, like blank flash
  always_comb begin
    next_s = s;
    for (int i = 0; i < DEPTH; i++) begin
      if (clr) next_s.w[i] = '1;
      else if (wr_en && wr_addr == AW'(i)) next_s.w[i] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) s <= '1;
    else     s <= next_s;
  end

  assign rd_data = s.w[rd_addr];
endmodule : spv_mem

// *** core/spv_port.sv ***
// serial program/verify port: link shifter and address/memory control
// assumes prog_clock_pin is the programmer's clock and stands low
// outside commands; hv_entry comes from the high-voltage detector
`timescale 1ns/1ns
`include "spv_cfg.svh"
// Contract
// RL1 - programmer holds clock and data low, then raises master clear high
// RL2 - while in the mode, all other device logic is held in reset
// RL3 - mode entry presets the counter to the configuration word 0x7FF
// RL4 - commands are six bits, sampled on falling edges, lsb first
// RL5 - programmer waits the gap delay after each command
// RL6 - data segment is start, 14 bits lsb first, stop
// RL7 - read drives data from second rising edge until 16th rising edge
// RL8 - load code 0010 and read code 0100 carry a data segment
// RL9 - increment, begin, end and bulk erase carry no data
// RL10 - load keeps the low 12 of the 14 bits in the latch
// RL11 - read shifts out current word with upper two bits zero
// RL12 - with protection on, protected program words read as zero
// RL13 - increment adds one and wraps 0x7FF to 0x000
// RL14 - space is 0x000-0x7FF, lower half user, upper half configuration
// RL15 - counter steps from 0x3FF to 0x400
// RL16 - configuration array holds 0x400-0x43F, ids at 0x400-0x403
// RL17 - id words read true contents even when protected
// RL18 - configuration word reachable only before first increment
// RL19 - trim backup survives erase unless counter is in configuration
// RL20 - programmer waits discharge delay after end programming
// RL21 - begin programs latch into current word without erase
// RL22 - bulk erase sets program memory and configuration word to ones
// RL23 - protection masks 0x040-0x3FE, keeps 0x000-0x03F and 0x3FF
// RL24 - unknown command codes change nothing
module spv_port
  import spv_pkg::*;
(
  input  wire logic clk,             // system clock, 20 MHz
  input  wire logic rst,             // synchronous reset, high
  input  wire logic hv_entry,        // master clear at high voltage
  input  wire logic prog_clock_pin,  // link clock from programmer
  input  wire logic prog_data_in,    // data pin level
  output logic      prog_data_out,   // data pin drive value
  output logic      prog_data_oe,    // data pin drive enable
  output logic      core_hold_reset, // hold rest of device in reset
  output logic      prog_pulse_on    // programming pulse active
);
  localparam logic [4:0] LAST_CMD = 5'(`SPV_CMD_BITS - 1);
  localparam logic [4:0] LAST_SEG = 5'(`SPV_SEG_BITS - 1);
  localparam logic [4:0] LAST_BIT = 5'(`SPV_DATA_BITS);
  localparam int PAD = `SPV_DATA_BITS - `SPV_CORE_BITS;
  localparam spv_core_s CORE_RST = '{
    mode: 1'b0, lrst: 1'b1, pc: `SPV_PC_ENTRY, fresh: 1'b1,
    seen: 1'b0, prog: 1'b0, latch: '0, cfgw: `SPV_ERASED,
    shadow: '0};

  // which store the counter points at
  function automatic spv_region_e spv_region(
    input logic [`SPV_ADDR_BITS-1:0] a,
    input logic                      f
  );
    spv_region_e r;
    if (f && a == `SPV_PC_ENTRY) r = RG_CFGW;
    else if (a <= `SPV_USER_TOP) r = RG_USER;
    else if (a <= `SPV_CFG_LAST) r = RG_CFG;
    else                         r = RG_NONE;
    return r;
  endfunction : spv_region

  // true for any code in the command set
  function automatic logic spv_known(input logic [3:0] k);
    logic ok;
    case (k)
      CMD_LOAD, CMD_READ, CMD_INC,
      CMD_BEGIN, CMD_END, CMD_ERASE: ok = 1'b1;
      default:                       ok = 1'b0;
    endcase
    return ok;
  endfunction : spv_known

  spv_link_s  l;
  spv_link_s  next_l;
  spv_drive_s d;
  spv_drive_s next_d;
  spv_core_s  c;
  spv_core_s  next_c;
  logic [5:0] cmd6;
  logic [3:0] bit_idx;
  logic       link_rst;
  logic       mode_s;
  logic       req_s;
  logic       ev;
  logic       cp_on;
  logic       in_cp;
  spv_region_e rg;
  logic [`SPV_CORE_BITS-1:0] rv;
  logic [`SPV_CORE_BITS-1:0] u_rd;
  logic [`SPV_CORE_BITS-1:0] g_rd;
  logic [`SPV_CORE_BITS-1:0] wdata;
  logic u_wr;
  logic g_wr;
  logic u_clr;
  logic g_clr;

  // link reset comes from clk side, released while the link clock idles
  assign link_rst = c.lrst;
  assign cmd6     = {prog_data_in, l.sh[5:1]};
  assign bit_idx  = 4'(l.cnt - 5'h01);

  // command and data shifter on falling edges
  always_comb begin
    next_l = l;
    case (l.ph)
      PH_CMD: begin
        next_l.sh  = cmd6;                          // see RL4
        next_l.cnt = l.cnt + 5'h01;
        if (l.cnt == LAST_CMD) begin
          next_l.cnt = '0;
          if (cmd6[3:0] == CMD_LOAD || cmd6[3:0] == CMD_READ) begin
            next_l.ph = PH_DATA;                    // see RL8
            next_l.rd = (cmd6[3:0] == CMD_READ);
          end
          // load reports at its stop cycle; others report now
          if (spv_known(cmd6[3:0]) && cmd6[3:0] != CMD_LOAD) begin
            next_l.req  = ~l.req;                   // see RL9
            next_l.code = cmd6[3:0];
          end                                       // see RL24
        end
      end
      PH_DATA: begin
        next_l.cnt = l.cnt + 5'h01;
        // shadow settled during the command gap, so it is stable here
        if (l.cnt == '0)
          next_l.tx = {{PAD{1'b0}}, c.shadow};      // see RL11
        if (l.cnt != '0 && l.cnt <= LAST_BIT)
          next_l.dsh = {prog_data_in, l.dsh[`SPV_DATA_BITS-1:1]};
        if (l.cnt == LAST_SEG) begin                // see RL6
          next_l.ph  = PH_CMD;
          next_l.cnt = '0;
          if (!l.rd) begin
            next_l.word = l.dsh;
            next_l.code = CMD_LOAD;
            next_l.req  = ~l.req;
          end
        end
      end
      default: next_l = '0;
    endcase
  end

  always_ff @(negedge prog_clock_pin or posedge link_rst) begin
    if (link_rst) l <= '0;
    else          l <= next_l;
  end

  // pin drive on rising edges: on at clock 2, off at clock 16
  always_comb begin
    next_d     = '0;
    next_d.oe  = l.ph == PH_DATA && l.rd &&
                 l.cnt != '0 && l.cnt <= LAST_BIT;  // see RL7
    next_d.dat = next_d.oe ? l.tx[bit_idx] : 1'b0;
  end

  always_ff @(posedge prog_clock_pin or posedge link_rst) begin
    if (link_rst) d <= '0;
    else          d <= next_d;
  end

  assign prog_data_out = d.dat;
  assign prog_data_oe  = d.oe;

  // high-voltage entry and link events into clk
  spv_sync #(.W(2)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({hv_entry, l.req}),
    .q   ({mode_s, req_s})
  );

  spv_mem #(
    .WIDTH (`SPV_CORE_BITS),
    .DEPTH (`SPV_USER_DEPTH)
  ) u_user (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (u_wr),
    .wr_addr (c.pc[9:0]),
    .wr_data (wdata),
    .clr     (u_clr),
    .rd_addr (c.pc[9:0]),
    .rd_data (u_rd)
  );

  spv_mem #(
    .WIDTH (`SPV_CORE_BITS),
    .DEPTH (`SPV_CFG_DEPTH)
  ) u_cfg (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (g_wr),
    .wr_addr (c.pc[5:0]),
    .wr_data (wdata),
    .clr     (g_clr),
    .rd_addr (c.pc[5:0]),
    .rd_data (g_rd)
  );

  // region decode and protected read value
  // an event that meets a mode exit is dropped, not executed
  assign ev    = c.mode && mode_s && (req_s != c.seen);
  assign rg    = spv_region(c.pc, c.fresh);           // see RL14
  assign cp_on = !c.cfgw[`SPV_CP_POS];
  assign in_cp = c.pc >= `SPV_CP_LO && c.pc <= `SPV_CP_HI;

  always_comb begin
    case (rg)
      RG_USER: rv = (cp_on && in_cp) ? '0 : u_rd;     // see RL12 RL23
      RG_CFG:  rv = g_rd;                             // see RL16 RL17
      RG_CFGW: rv = c.cfgw;
      default: rv = '0;
    endcase
  end

  // command execution on the system clock
  always_comb begin
    next_c      = c;
    next_c.mode = mode_s;
    next_c.seen = req_s;
    u_wr        = 1'b0;
    g_wr        = 1'b0;
    u_clr       = 1'b0;
    g_clr       = 1'b0;
    wdata       = c.latch & ((rg == RG_USER) ? u_rd : g_rd);
    if (!mode_s) begin                                // see RL1
      next_c.pc    = `SPV_PC_ENTRY;                   // see RL3
      next_c.fresh = 1'b1;
      next_c.prog  = 1'b0;
      next_c.lrst  = 1'b1;
    end else begin
      next_c.lrst = 1'b0;
      if (ev) begin
        case (spv_cmd_e'(l.code))
          CMD_LOAD: next_c.latch = l.word[`SPV_CORE_BITS-1:0]; // see RL10
          CMD_READ: next_c.shadow = rv;               // see RL11
          CMD_INC: begin
            next_c.pc    = c.pc + 11'h001;            // see RL13 RL15
            next_c.fresh = 1'b0;                      // see RL18
          end
          CMD_BEGIN: begin
            // flash only clears bits, so programming ands into old
            next_c.prog = 1'b1;                       // see RL21
            u_wr        = (rg == RG_USER);
            g_wr        = (rg == RG_CFG);
            if (rg == RG_CFGW) next_c.cfgw = c.cfgw & c.latch;
          end
          CMD_END: next_c.prog = 1'b0;
          CMD_ERASE: begin
            u_clr       = 1'b1;                       // see RL22
            next_c.cfgw = `SPV_ERASED;
            g_clr       = c.pc[10] && rg != RG_CFGW;  // see RL19
          end
          default: next_c = next_c;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) c <= CORE_RST;
    else     c <= next_c;
  end

  assign core_hold_reset = c.mode;                    // see RL2
  assign prog_pulse_on   = c.prog;

  a_entry_pc: assert property (@(posedge clk) disable iff (rst) // see RL3
    $rose(c.mode) |-> c.pc == `SPV_PC_ENTRY && c.fresh)
    else $error("counter not preset on entry");

  a_inc_step: assert property (@(posedge clk) disable iff (rst) // see RL13
    ev && l.code == CMD_INC |=> c.pc == 11'($past(c.pc) + 11'h001))
    else $error("increment did not add one");

  a_user_to_cfg: assert property (@(posedge clk) disable iff (rst) // see RL15
    ev && l.code == CMD_INC && c.pc == `SPV_USER_TOP
    |=> c.pc == `SPV_CFG_BASE)
    else $error("counter did not step into configuration space");

  a_cfgw_gone: assert property (@(posedge clk) disable iff (rst) // see RL18
    c.mode && mode_s && !c.fresh |=> !c.fresh && rg != RG_CFGW)
    else $error("configuration word came back");

  a_load_trim: assert property (@(posedge clk) disable iff (rst) // see RL10
    ev && l.code == CMD_LOAD
    |=> c.latch == $past(l.word[`SPV_CORE_BITS-1:0]))
    else $error("latch does not hold low bits of load");

  a_cp_mask: assert property (@(posedge clk) disable iff (rst) // see RL23
    ev && l.code == CMD_READ && cp_on && in_cp && rg == RG_USER
    |=> c.shadow == '0)
    else $error("protected word leaked");

  a_id_open: assert property (@(posedge clk) disable iff (rst) // see RL17
    ev && l.code == CMD_READ && c.pc >= `SPV_CFG_BASE &&
    c.pc <= `SPV_ID_LAST |=> c.shadow == $past(g_rd))
    else $error("id word not read true");

  a_erase_ones: assert property (@(posedge clk) disable iff (rst) // see RL22
    ev && l.code == CMD_ERASE && !c.pc[10]
    |-> u_clr && !g_clr ##1 c.cfgw == `SPV_ERASED)
    else $error("erase result wrong");

  a_cmd_len: assert property ( // see RL4
    @(negedge prog_clock_pin) disable iff (link_rst)
    l.ph == PH_CMD && l.cnt == '0 |-> (l.ph == PH_CMD) [*6] ##1 l.cnt == '0)
    else $error("command length not six");

  a_seg_len: assert property ( // see RL6
    @(negedge prog_clock_pin) disable iff (link_rst)
    l.ph == PH_DATA && l.cnt == LAST_SEG |=> l.ph == PH_CMD && l.cnt == '0)
    else $error("data segment not sixteen cycles");

  a_drive_win: assert property ( // see RL7
    @(posedge prog_clock_pin) disable iff (link_rst)
    $rose(d.oe) |-> l.cnt == 5'h02 && l.rd ##14 !d.oe)
    else $error("data drive window wrong");

  a_ignore_cmd: assert property ( // see RL24
    @(negedge prog_clock_pin) disable iff (link_rst)
    l.ph == PH_CMD && l.cnt == LAST_CMD && !spv_known(cmd6[3:0])
    |=> l.ph == PH_CMD && $stable(l.req))
    else $error("unknown code acted on");

  a_exit_preset: assert property (@(posedge clk) disable iff (rst) // see RL3
    !mode_s |=> c.pc == `SPV_PC_ENTRY && c.fresh && c.lrst)
    else $error("counter not preset while out of mode");

  a_prog_span: assert property (@(posedge clk) disable iff (rst) // see RL21
    ev && l.code == CMD_BEGIN |=> c.prog)
    else $error("programming pulse did not start");

  a_erase_cfg: assert property (@(posedge clk) disable iff (rst) // see RL19
    ev && l.code == CMD_ERASE && c.pc[10] &&
    !(c.fresh && c.pc == `SPV_PC_ENTRY) |-> g_clr)
    else $error("configuration array not erased");

  a_drive_read: assert property ( // see RL7
    @(posedge prog_clock_pin) disable iff (link_rst)
    d.oe |-> l.ph == PH_DATA && l.rd)
    else $error("data pin driven outside a read");
endmodule : spv_port

// *** sim/spv_prog_model.sv ***
// programmer model: makes the link clock and drives the data wire
// assumes the bench resolves the wire from the port's drive enable
`timescale 1ns/1ns
module spv_prog_model #(
  parameter int GAP_NS = 350,  // command gap, above the 250 ns minimum
  parameter int DIS_NS = 1000  // discharge wait after end programming
) (
  output logic      link_clk,  // link clock, low outside frames
  output logic      drv,       // model drive onto the data wire
  input  wire logic dat,       // resolved data wire
  input  wire logic oe         // port drive enable
);
  // clock and data low before the bench raises entry
  initial begin
    link_clk = 1'b0;
    drv      = 1'b0;
  end

  // one 15 ns link cycle; data moves 1 ns after a fall to keep hold
  task automatic pulse(input logic b, output logic d, output logic e);
    #1 drv = b;
    #6 link_clk = 1'b1;
    #4 e = oe;
    d = dat;
    #4 link_clk = 1'b0;
  endtask : pulse

  // six code bits lsb first, then the gap
  task automatic cmd(input logic [5:0] c);
    logic d;
    logic e;
    for (int i = 0; i < 6; i++) begin
      pulse(c[i], d, e);
    end
    #GAP_NS;
    if (c[3:0] == 4'he) #DIS_NS;
  endtask : cmd

  // start, 14 bits lsb first, stop; a read leaves the wire toggling so
  // a missing drive cannot hide behind a held level
  task automatic seg(input logic [13:0] w, input logic rd,
                     output logic [13:0] r, output logic [15:0] en);
    logic d;
    logic e;
    for (int k = 0; k < 16; k++) begin
      pulse((rd || k == 0 || k == 15) ? ~drv : w[k-1], d, e);
      en[k] = e;
      if (k > 0 && k < 15) r[k-1] = d;
    end
    #GAP_NS;
  endtask : seg
endmodule : spv_prog_model

// *** sim/tb.sv ***
// bench for the program/verify port: walks the address space over the link
// assumes the programmer model drives the link; no checker file is bound
`timescale 1ns/1ns
module tb;
  logic        clk;
  logic        rst;
  logic        hv_entry;
  logic        link_clk;
  logic        drv;
  logic        dat;
  logic        prog_data_out;
  logic        prog_data_oe;
  logic        core_hold_reset;
  logic        prog_pulse_on;
  logic [10:0] pc;
  int          failures;
  int          check_count;
  int          cycles;

  // wire level: the port when it drives, else the model
  assign dat = prog_data_oe ? prog_data_out : drv;

  spv_port i_spv_port (
    .clk             (clk),
    .rst             (rst),
    .hv_entry        (hv_entry),
    .prog_clock_pin  (link_clk),
    .prog_data_in    (dat),
    .prog_data_out   (prog_data_out),
    .prog_data_oe    (prog_data_oe),
    .core_hold_reset (core_hold_reset),
    .prog_pulse_on   (prog_pulse_on)
  );

  spv_prog_model i_spv_prog_model (
    .link_clk (link_clk),
    .drv      (drv),
    .dat      (dat),
    .oe       (prog_data_oe)
  );

  task automatic close_out();
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_b

  // the bench mirrors the counter to know how far to step
  task automatic inc();
    i_spv_prog_model.cmd(6'h06);
    pc = pc + 11'h001;
  endtask : inc

  task automatic go(input logic [10:0] a);
    while (pc != a) inc();
  endtask : go

  task automatic rd(input logic [11:0] exp);
    logic [13:0] r;
    logic [15:0] en;
    i_spv_prog_model.cmd(6'h04);
    i_spv_prog_model.seg(14'h0000, 1'b1, r, en);
    chk_w({2'b00, r}, {4'h0, exp});
    chk_w(en, 16'h7ffe);
  endtask : rd

  // upper code bits set on purpose: they must be ignored
  task automatic prg(input logic [13:0] w);
    logic [13:0] r;
    logic [15:0] en;
    i_spv_prog_model.cmd(6'h32);
    i_spv_prog_model.seg(w, 1'b0, r, en);
    i_spv_prog_model.cmd(6'h08);
    chk_b(prog_pulse_on, 1'b1);
    i_spv_prog_model.cmd(6'h0e);
    chk_b(prog_pulse_on, 1'b0);
  endtask : prg

  task automatic enter();
    @(posedge clk) hv_entry <= 1'b0;
    repeat (6) @(posedge clk);
    chk_b(core_hold_reset, 1'b0);
    hv_entry <= 1'b1;
    repeat (6) @(posedge clk);
    chk_b(core_hold_reset, 1'b1);
    pc = 11'h7ff;
  endtask : enter

  // fresh entry, then every unknown code leaves the config word reachable
  task automatic t_entry();
    enter();
    rd(12'hfff);
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {2, 4, 6, 8, 9, 14})) i_spv_prog_model.cmd(6'(c + 32));
    end
    rd(12'hfff);
  endtask : t_entry

  task automatic t_write();
    inc();
    prg(14'h3a5c);
    rd(12'ha5c);
    prg(14'h00ff);
    rd(12'h05c);
    go(11'h040);
    prg(14'h0123);
    go(11'h3ff);
    prg(14'h0456);
    inc();
    rd(12'hfff);
    prg(14'h0789);
    go(11'h404);
    prg(14'h0321);
  endtask : t_write

  task automatic t_protect();
    enter();
    prg(14'h0fef);
    rd(12'hfef);
    inc();
    rd(12'h05c);
    go(11'h040);
    rd(12'h000);
    go(11'h3ff);
    rd(12'h456);
    inc();
    rd(12'h789);
    go(11'h43f);
    rd(12'hfff);
    go(11'h7ff);
    rd(12'h000);
    inc();
    rd(12'h05c);
  endtask : t_protect

  task automatic t_erase();
    enter();
    i_spv_prog_model.cmd(6'h09);
    rd(12'hfff);
    inc();
    rd(12'hfff);
    go(11'h400);
    rd(12'h789);
    go(11'h404);
    rd(12'h321);
    enter();
    inc();
    go(11'h400);
    i_spv_prog_model.cmd(6'h09);
    rd(12'hfff);
    go(11'h404);
    rd(12'hfff);
  endtask : t_erase

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // main sequence
  initial begin
    rst         = 1'b1;
    hv_entry    = 1'b0;
    failures    = 0;
    check_count = 0;
    cycles      = 0;
    pc          = 11'h7ff;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_entry();
    t_write();
    t_protect();
    t_erase();
    close_out();
  end

  // the run needs about 50k cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      close_out();
    end
  end
endmodule : tb
